// ---- bench/adc_model.sv ----
// Converter model on the far side of the analog input path.
// Assumes one-cycle start pulses on clk_in; answers LAT cycles later.
`timescale 1ns/1ps
`default_nettype none
module adc_model #(
  parameter int LAT = 8
) (
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  input  wire logic        start_in,
  input  wire logic [1:0]  channel_in,
  output logic             done_out,
  output logic [11:0]      code_out
);
  int cnt_r;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_r <= 0;
      done_out <= 1'b0;
      code_out <= 12'h000;
    end else begin
      done_out <= cnt_r == 1;
      cnt_r <= start_in ? LAT : (cnt_r > 0 ? cnt_r - 1 : 0);
      // Code toggles while converting so a stale read cannot pass
      if (start_in || cnt_r > 1) code_out <= ~code_out;
      else if (cnt_r == 1) code_out <= 12'hac0 | 12'(channel_in);
    end
  end
endmodule
`default_nettype wire

// ---- bench/analog_io_device_tb.sv ----
// Self-checking bench for the analog I/O device.
// Assumes the converter model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module analog_io_device_tb;
  logic [7:0]               dev = 8'h09;
  logic [7:0]               rdata, got;
  logic                     clk_in = 1'b0, nrst_in = 1'b0, rvalid, done, start, irq;
  logic [1:0]               chan;
  logic [11:0]              code, dac0, dac1;
  analog_io_pkg::host_req_t req = '0;
  int                       errors = 0, cmp_count = 0;
  always #2 clk_in = ~clk_in;
  analog_io_device uut (.clk_in(clk_in), .nrst_in(nrst_in), .device_number_in(dev),
    .host_req_in(req), .rdata_out(rdata), .rdata_valid_out(rvalid), .adc_done_in(done),
    .adc_code_in(code), .adc_start_out(start), .adc_channel_out(chan), .irq_out(irq),
    .dac0_out(dac0), .dac1_out(dac1));
  adc_model adc (.clk_in(clk_in), .nrst_in(nrst_in), .start_in(start), .channel_in(chan),
    .done_out(done), .code_out(code));
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic end_sim;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // A gap edge after each request keeps strobes from merging
  task automatic acc(input logic w, input logic [2:0] i, input logic h, input logic [7:0] d);
    req <= '{w, !w, i, h, d};
    @(posedge clk_in) #1;
    got = rvalid ? rdata : 8'hxx;
    req <= '0;
    @(posedge clk_in) #1;
  endtask
  task automatic rd(input logic [2:0] i, input logic h, input logic [7:0] e, input string n);
    acc(0, i, h, 8'h00);
    chk(n, e, got);
  endtask
  initial begin
    repeat (20) @(posedge clk_in);
    #1 nrst_in = 1'b1;
    acc(1, 3'h1, 1, 8'h01);
    acc(1, 3'h3, 0, 8'h34);
    acc(1, 3'h3, 1, 8'ha5);
    chk("dac1", 12'h534, dac1);
    acc(1, 3'h1, 1, 8'h00);
    acc(1, 3'h3, 0, 8'hab);
    acc(1, 3'h3, 1, 8'h00);
    chk("dac0", 12'h0ab, dac0);
    acc(1, 3'h1, 1, 8'h02);
    acc(1, 3'h3, 1, 8'h0f);
    dev = 8'h08;
    acc(1, 3'h1, 1, 8'h01);
    acc(1, 3'h3, 1, 8'h0e);
    dev = 8'h09;
    chk("dac0 held", 12'h0ab, dac0);
    chk("dac1 held", 12'h534, dac1);
    acc(1, 3'h0, 1, 8'h02);
    acc(1, 3'h0, 0, 8'h00);
    // Multiplexer settling time before the first start
    repeat (5000) @(posedge clk_in) #1;
    chk("mux", 2'h2, chan);
    acc(1, 3'h0, 0, 8'h01);
    acc(1, 3'h0, 0, 8'h07);
    rd(3'h0, 0, 8'h05, "busy");
    for (int n = 0; n < 50 && irq !== 1'b1; n++) @(posedge clk_in) #1;
    chk("irq", 1, irq);
    if (irq !== 1'b1) end_sim;
    rd(3'h0, 0, 8'h06, "done");
    rd(3'h0, 1, 8'h00, "status hi");
    acc(1, 3'h0, 0, 8'h00);
    chk("irq off", 0, irq);
    rd(3'h2, 0, 8'hc2, "result lo");
    rd(3'h2, 1, 8'h0a, "result hi");
    rd(3'h1, 0, 8'h00, "reg1");
    acc(1, 3'h0, 0, 8'h01);
    for (int n = 0; n < 50; n++) begin
      acc(0, 3'h0, 0, 8'h00);
      if (got[0] === 1'b0) break;
    end
    chk("poll", 8'h02, got);
    if (got !== 8'h02) end_sim;
    chk("poll irq", 0, irq);
    end_sim;
  end
endmodule
`default_nettype wire

// ---- bench/analog_io_sva.sv ----
// Port assertions for the analog I/O device.
// Assumes binding onto analog_io_device.
`timescale 1ns/1ps
`default_nettype none
module analog_io_sva #(
  parameter int DATA_W = analog_io_pkg::DATA_W
) (
  input wire logic                     clk_in,
  input wire logic                     nrst_in,
  input wire logic [7:0]               device_number_in,
  input wire analog_io_pkg::host_req_t host_req_in,
  input wire logic [7:0]               rdata_out,
  input wire logic                     rdata_valid_out,
  input wire logic                     adc_start_out,
  input wire logic                     irq_out,
  input wire logic [DATA_W-1:0]        dac0_out,
  input wire logic [DATA_W-1:0]        dac1_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  analog_io_pkg::host_req_t q;
  logic                     sel;
  logic                     rd;
  logic                     wr0;
  logic                     val;
  assign q   = host_req_in;
  assign sel = device_number_in == analog_io_pkg::DEV_ANALOG;
  assign rd  = sel && q.rd;
  assign wr0 = sel && q.wr && q.index == 3'h0 && !q.high_byte;
  assign val = sel && q.wr && q.index == 3'h3 && q.high_byte;
  AST_RVALID: assert property (rd |=> rdata_valid_out)
    else $error("read not answered");
  AST_NOSEL: assert property (!sel && (q.wr || q.rd) |=> !rdata_valid_out && !adc_start_out)
    else $error("other device answered");
  AST_START: assert property (adc_start_out |-> $past(wr0 && q.wdata[0]))
    else $error("start without request");
  AST_IRQ_OFF: assert property (wr0 && !q.wdata[2] |-> ##2 !irq_out)
    else $error("irq while disabled");
  AST_RES_HI: assert property (rd && q.index == 3'h2 && q.high_byte |=> rdata_out[7:4] == 4'h0)
    else $error("result top bits set");
  AST_ZERO: assert property (rd && (q.index == 3'h0 ? q.high_byte : q.index != 3'h2)
    |=> rdata_out == 8'h00)
    else $error("unused read not zero");
  AST_STAT: assert property (rd && q.index == 3'h0 |=> rdata_out[7:3] == 5'h00)
    else $error("status unused bits set");
  AST_HOLD: assert property (!$past(val) |-> $stable(dac0_out) && $stable(dac1_out))
    else $error("output changed unwritten");
  AST_ONE: assert property (val |=> $stable(dac0_out) || $stable(dac1_out))
    else $error("both outputs changed");
  COV_READ: cover property (rdata_valid_out);
  COV_IRQ: cover property ($rose(irq_out));
  COV_VAL: cover property (val);
endmodule
bind analog_io_device analog_io_sva #(.DATA_W(DATA_W)) chk (.clk_in(clk_in), .nrst_in(nrst_in),
  .device_number_in(device_number_in), .host_req_in(host_req_in), .rdata_out(rdata_out),
  .rdata_valid_out(rdata_valid_out), .adc_start_out(adc_start_out), .irq_out(irq_out),
  .dac0_out(dac0_out), .dac1_out(dac1_out));
`default_nettype wire

// ---- logic/analog_io_device.sv ----
// Analog I/O device register block: input converter control and output values.
// Assumes host strobes are synchronous to clk_in, one cycle wide, and that the
// converter runs on clk_in with a one-cycle done pulse.
`timescale 1ns/1ps
`default_nettype none

module analog_io_device #(
  parameter int DATA_W = analog_io_pkg::DATA_W
) (
  input  wire logic                      clk_in,
  input  wire logic                      nrst_in,
  input  wire logic [7:0]                device_number_in,
  input  wire analog_io_pkg::host_req_t  host_req_in,
  output logic [7:0]                     rdata_out,
  output logic                           rdata_valid_out,
  input  wire logic                      adc_done_in,
  input  wire logic [DATA_W-1:0]         adc_code_in,
  output logic                           adc_start_out,
  output logic [1:0]                     adc_channel_out,
  output logic                           irq_out,
  output logic [DATA_W-1:0]              dac0_out,
  output logic [DATA_W-1:0]              dac1_out
);

  // ****************************************
  // Checks and state
  // ****************************************
  initial begin
    if (DATA_W < 1 || DATA_W > 16) begin
      $error("DATA_W must be 1 to 16");
    end
  end

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_BUSY = 3'b010,
    ST_DONE = 3'b100
  } conv_state_t;

  conv_state_t       state_r;
  logic [7:0]        ctrl_lo_r;
  logic [7:0]        ain_ch_r;
  logic [7:0]        aout_ch_r;
  logic [7:0]        value_lo_r;
  logic [DATA_W-1:0] result_r;
  logic              sel;
  logic              wr_lo;
  logic              wr_hi;
  logic [15:0]       word_rd;

  assign sel   = (device_number_in == analog_io_pkg::DEV_ANALOG);
  assign wr_lo = sel && host_req_in.wr && !host_req_in.high_byte;
  assign wr_hi = sel && host_req_in.wr && host_req_in.high_byte;

  function automatic logic hit(input logic [2:0] idx, input logic [2:0] reg_idx);
    hit = (idx == reg_idx);
  endfunction

  // ****************************************
  // Control writes
  // ****************************************
  // Bit 1 and bits 3 to 7 are dropped on write
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctrl_lo_r <= 8'h00;
    end else if (wr_lo && hit(host_req_in.index, analog_io_pkg::REG_AIN_CTRL)) begin
      ctrl_lo_r <= host_req_in.wdata & 8'h05;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ain_ch_r <= analog_io_pkg::CHANNEL_RESET;
    end else if (wr_hi && hit(host_req_in.index, analog_io_pkg::REG_AIN_CTRL)) begin
      ain_ch_r <= host_req_in.wdata;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      aout_ch_r <= analog_io_pkg::CHANNEL_RESET;
    end else if (wr_hi && hit(host_req_in.index, analog_io_pkg::REG_AOUT_CTRL)) begin
      aout_ch_r <= host_req_in.wdata;
    end
  end

  // ****************************************
  // Output converter values
  // ****************************************
  // Low byte is staged so the converter never sees a half-written code
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      value_lo_r <= 8'h00;
    end else if (wr_lo && hit(host_req_in.index, analog_io_pkg::REG_AOUT_VALUE)) begin
      value_lo_r <= host_req_in.wdata;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      dac0_out <= DATA_W'(analog_io_pkg::VALUE_RESET);
      dac1_out <= DATA_W'(analog_io_pkg::VALUE_RESET);
    end else if (wr_hi && hit(host_req_in.index, analog_io_pkg::REG_AOUT_VALUE)) begin
      if (aout_ch_r == 8'h00) begin
        dac0_out <= DATA_W'({host_req_in.wdata, value_lo_r});
      end else if (aout_ch_r == 8'h01) begin
        dac1_out <= DATA_W'({host_req_in.wdata, value_lo_r});
      end
    end
  end

  // ****************************************
  // Conversion sequencing
  // ****************************************
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_r       <= ST_IDLE;
      adc_start_out <= 1'b0;
    end else begin
      adc_start_out <= 1'b0;
      case (state_r)
        ST_IDLE, ST_DONE: begin
          if (wr_lo && hit(host_req_in.index, analog_io_pkg::REG_AIN_CTRL)
              && host_req_in.wdata[analog_io_pkg::BIT_START]) begin
            state_r       <= ST_BUSY;
            adc_start_out <= 1'b1;
          end
        end
        ST_BUSY: begin
          if (adc_done_in) begin
            state_r <= ST_DONE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Only channels 0 to 3 reach the multiplexer
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      adc_channel_out <= 2'h0;
    end else begin
      adc_channel_out <= ain_ch_r[1:0];
    end
  end

  // Result latches only when start is written back to zero
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      result_r <= '0;
    end else if (state_r == ST_DONE && wr_lo
                 && hit(host_req_in.index, analog_io_pkg::REG_AIN_CTRL)
                 && !host_req_in.wdata[analog_io_pkg::BIT_START]) begin
      result_r <= adc_code_in;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= (state_r == ST_DONE) && ctrl_lo_r[analog_io_pkg::BIT_IRQ_EN];
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  always_comb begin
    word_rd = 16'h0000;
    case (host_req_in.index)
      analog_io_pkg::REG_AIN_CTRL: begin
        word_rd[analog_io_pkg::BIT_BUSY]   = (state_r == ST_BUSY);
        word_rd[analog_io_pkg::BIT_DONE]   = (state_r == ST_DONE);
        word_rd[analog_io_pkg::BIT_IRQ_EN] = ctrl_lo_r[analog_io_pkg::BIT_IRQ_EN];
      end
      analog_io_pkg::REG_AIN_RESULT: begin
        word_rd = 16'(result_r);
      end
      default: begin
        word_rd = 16'h0000;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_out       <= 8'h00;
      rdata_valid_out <= 1'b0;
    end else begin
      rdata_valid_out <= sel && host_req_in.rd;
      rdata_out       <= host_req_in.high_byte ? word_rd[15:8] : word_rd[7:0];
    end
  end

endmodule

`default_nettype wire

// ---- logic/analog_io_pkg.sv ----
// Constants and carrier types for the analog I/O device register block.
// Assumes a byte-wide host port with a word index, byte select and device number.
package analog_io_pkg;

  localparam logic [7:0] DEV_ANALOG        = 8'h09;
  localparam logic [2:0] REG_AIN_CTRL      = 3'h0;
  localparam logic [2:0] REG_AOUT_CTRL     = 3'h1;
  localparam logic [2:0] REG_AIN_RESULT    = 3'h2;
  localparam logic [2:0] REG_AOUT_VALUE    = 3'h3;
  localparam int         BIT_START         = 0;
  localparam int         BIT_SHORT         = 1;
  localparam int         BIT_IRQ_EN        = 2;
  localparam int         BIT_BUSY          = 0;
  localparam int         BIT_DONE          = 1;
  localparam int         CH_LSB            = 8;
  localparam int         DATA_W            = 12;
  localparam int         AIN_CHANNELS      = 4;
  localparam int         AOUT_CHANNELS     = 2;
  localparam logic [7:0] CHANNEL_RESET     = 8'h00;
  localparam logic [11:0] VALUE_RESET      = 12'h000;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] index;
    logic       high_byte;
    logic [7:0] wdata;
  } host_req_t;

  typedef struct packed {
    logic              start;
    logic [1:0]        channel;
    logic [DATA_W-1:0] code;
    logic              done;
  } adc_link_t;

endpackage
